// ---- sdd_regs.vh ----
// constants for the sigma-delta decimator block
`ifndef SDD_REGS_VH
`define SDD_REGS_VH
`define SDD_MOD_DIV 8
`define SDD_OUT_DIV 256
`define SDD_DECIM 32
`define SDD_ACC_W 17
`define SDD_OUT_W 15
`define SDD_POS_FULL 16'h7FFF
`define SDD_CREG_RST 8'h00
`define SDD_NUM_CREG 5
`define SDD_GAIN_LSB 0
`define SDD_GAIN_MSB 2
`define SDD_GROUP_DELAY_NS 25000
`define SDD_CLK_NS 10
`endif

// ---- sdd_decimator.v ----
// sinc-cubed decimator for the encoder channel, with clock divider and control registers
//
// Overview of operation
// - take one modulator bit every eighth internal master clock cycle
// - decimate from internal clock over 8 to over 256, output 15-bit words
// - response is three cascaded 32-tap moving sums, sinc cubed
// - output updates once per 256 internal clocks; rate has no separate setting
// - internal master clock comes from external clock through programmable divider
// - gain field bits 2..0 select 0,6,12,18,20,26,32,38 dB
// - five readable writable 8-bit control registers, bit 7 most significant
// - keep decimation group delay minimal, about 25 microseconds
// - 16-bit mode shifts result left, LSB zero; positive overload gives 0x7FFF
// - mixed mode keeps 15 bits; transfer MSB flags control or data
// - reset clears control registers and all digital state including accumulators
`timescale 1ns/1ps
`include "sdd_regs.vh"
module sdd_decimator (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire [7:0] mclk_div,
	input wire mod_bit,
	input wire cfg_we,
	input wire [2:0] cfg_addr,
	input wire [7:0] cfg_wdata,
	input wire mixed_mode,
	input wire ctrl_flag,
	output reg [7:0] cfg_rdata,
	output reg [2:0] input_gain_sel,
	output reg [5:0] input_gain_db,
	output reg internal_master_clock,
	output reg [14:0] sample_reg,
	output reg [15:0] sample_word,
	output reg sample_valid
);
	localparam W = `SDD_ACC_W;
	reg [7:0] div_cnt_reg;
	reg internal_master_clock_en;
	reg [2:0] ph8_reg;
	reg [7:0] ph256_reg;
	reg [7:0] creg [0:`SDD_NUM_CREG-1];
	reg [W-1:0] i1_reg, i2_reg, i3_reg;
	reg [W-1:0] c1_reg, c2_reg, c3_reg;
	wire [W-1:0] d0, d1, d2, d3;
	wire [W-1:0] x_in;
	wire [14:0] res15;
	wire sat;
	integer k;

	// divide external clock; a zero setting runs at full rate
	always @(posedge mclk) begin
		if (rst) begin
			div_cnt_reg <= 8'h00;
			internal_master_clock_en <= 1'b0;
			internal_master_clock <= 1'b0;
		end else if (ce) begin
			if (div_cnt_reg >= mclk_div) begin
				div_cnt_reg <= 8'h00;
				internal_master_clock_en <= 1'b1;
				internal_master_clock <= ~internal_master_clock;
			end else begin
				div_cnt_reg <= div_cnt_reg + 8'h01;
				internal_master_clock_en <= 1'b0;
			end
		end
	end

	// unipolar bit mapped to +1 / -1 so the CIC output is two's complement
	assign x_in = mod_bit ? {{(W-1){1'b0}}, 1'b1} : {W{1'b1}};

	// 17 bits: gain 32^3 reaches +32768, which 16 bits signed would wrap to the negative end
	always @(posedge mclk) begin
		if (rst) begin
			ph8_reg <= 3'h0;
			i1_reg <= {W{1'b0}};
			i2_reg <= {W{1'b0}};
			i3_reg <= {W{1'b0}};
		end else if (ce && internal_master_clock_en) begin
			ph8_reg <= ph8_reg + 3'h1;
			if (ph8_reg == 3'h7) begin
				i1_reg <= i1_reg + x_in;
				i2_reg <= i2_reg + i1_reg;
				i3_reg <= i3_reg + i2_reg;
			end
		end
	end

	assign d0 = i3_reg;
	assign d1 = d0 - c1_reg;
	assign d2 = d1 - c2_reg;
	assign d3 = d2 - c3_reg;
	// full scale is 32768; clip to 15-bit signed range
	assign sat = ~d3[W-1] & (d3[W-2] | (&d3[W-3:1]));
	assign res15 = sat ? 15'h3FFF : d3[W-2:1];

	// combs run at the output rate: one differential delay of 32 input bits
	always @(posedge mclk) begin
		if (rst) begin
			ph256_reg <= 8'h00;
			c1_reg <= {W{1'b0}};
			c2_reg <= {W{1'b0}};
			c3_reg <= {W{1'b0}};
			sample_reg <= 15'h0000;
			sample_word <= 16'h0000;
			sample_valid <= 1'b0;
		end else if (ce) begin
			sample_valid <= 1'b0;
			if (internal_master_clock_en) begin
				ph256_reg <= ph256_reg + 8'h01;
				if (ph256_reg == 8'hFF) begin
					c1_reg <= d0;
					c2_reg <= d1;
					c3_reg <= d2;
					sample_reg <= res15;
					sample_valid <= 1'b1;
					if (mixed_mode)
						sample_word <= {ctrl_flag, res15};
					else if (sat)
						sample_word <= `SDD_POS_FULL;
					else
						sample_word <= {res15, 1'b0};
				end
			end
		end
	end

	// control registers A..E
	always @(posedge mclk) begin
		if (rst) begin
			for (k = 0; k < `SDD_NUM_CREG; k = k + 1)
				creg[k] <= `SDD_CREG_RST;
			cfg_rdata <= 8'h00;
			input_gain_sel <= 3'h0;
			input_gain_db <= 6'h00;
		end else if (ce) begin
			if (cfg_we && cfg_addr < 3'h5)
				creg[cfg_addr] <= cfg_wdata;
			cfg_rdata <= (cfg_addr < 3'h5) ? creg[cfg_addr] : 8'h00;
			input_gain_sel <= creg[3][`SDD_GAIN_MSB:`SDD_GAIN_LSB];
			case (creg[3][`SDD_GAIN_MSB:`SDD_GAIN_LSB])
			3'h0: input_gain_db <= 6'd0;
			3'h1: input_gain_db <= 6'd6;
			3'h2: input_gain_db <= 6'd12;
			3'h3: input_gain_db <= 6'd18;
			3'h4: input_gain_db <= 6'd20;
			3'h5: input_gain_db <= 6'd26;
			3'h6: input_gain_db <= 6'd32;
			default: input_gain_db <= 6'd38;
			endcase
		end
	end
endmodule

// ---- sdd_mod_src.sv ----
// modulator bit source holding a steady level
`timescale 1ns/1ps
module sdd_mod_src (
	input wire mclk,
	input wire pat,
	output reg mod_bit = 1'h0
);
	// frame sync loop-back is host wiring; this source only models the modulator
	always @(posedge mclk) mod_bit <= #1 pat;
endmodule

// ---- sdd_decimator_props.sv ----
// decimator port assertions
`timescale 1ns/1ps
module sdd_decimator_props (
	input wire mclk,
	input wire rst,
	input wire [2:0] cfg_addr,
	input wire mixed_mode,
	input wire ctrl_flag,
	input wire [7:0] cfg_rdata,
	input wire [2:0] input_gain_sel,
	input wire [5:0] input_gain_db,
	input wire [14:0] sample_reg,
	input wire [15:0] sample_word,
	input wire sample_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_valid_pulse: assert property (sample_valid |=> !sample_valid) else $error("pulse");
	a_out_rate: assert property (sample_valid |-> ##256 sample_valid) else $error("rate");
	a_reg_hold: assert property (!sample_valid |-> $stable(sample_reg)) else $error("hold");
	a_bad_addr: assert property (cfg_addr > 3'h4 |=> !cfg_rdata) else $error("addr");
	a_gain_table: assert property (input_gain_db == input_gain_sel[2] * 6'h14 + input_gain_sel[1:0] * 6'h06)
		else $error("gain");
	a_word_shift: assert property (sample_valid && !$past(mixed_mode) |-> sample_word == 16'h7FFF
		|| sample_word == {sample_reg, 1'h0}) else $error("word");
	a_mixed_word: assert property (sample_valid && $past(mixed_mode) |->
		sample_word == {$past(ctrl_flag), sample_reg}) else $error("mixed");
	a_reset_clears: assert property (disable iff (1'h0) rst |=> !sample_valid && !sample_reg)
		else $error("reset");
endmodule
bind sdd_decimator sdd_decimator_props u_props (.*);

// ---- sdd_decimator_tb_top.sv ----
// decimator bench: gain codes, refused write, positive overload in 16-bit mode, negative full scale in mixed mode
`timescale 1ns/1ps
module sdd_decimator_tb_top;
	reg mclk = 1'h0, rst = 1'h1, cfg_we = 1'h0, mixed_mode = 1'h0, ctrl_flag = 1'h0, pat = 1'h0;
	reg [2:0] cfg_addr = 3'h0;
	reg [7:0] cfg_wdata = 8'h00;
	reg [7:0] last_wd = 8'h00;
	wire ce = 1'h1;
	wire [7:0] mclk_div = 8'h00;
	wire mod_bit, internal_master_clock, sample_valid;
	wire [7:0] cfg_rdata;
	wire [2:0] input_gain_sel;
	wire [5:0] input_gain_db;
	wire [14:0] sample_reg;
	wire [15:0] sample_word;
	logic [31:0] notes[$], nt;
	int err_count = 0, n_checks = 0, i, k;
	sdd_mod_src u_src (.*);
	sdd_decimator DUT (.*);
	initial forever #5 mclk = ~mclk;
	task cmp(input string w, input logic [15:0] e, g);
		n_checks++;
		err_count += g !== e;
		if (g !== e) $display("BAD %s exp %h got %h", w, e, g);
	endtask
	task conclude;
		if (err_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) if (sample_valid === 1'h1 && notes.size() > 0) begin
		nt = notes.pop_front();
		if (nt[31]) cmp("sample", nt[30:16], sample_reg);
		if (nt[31]) cmp("word", nt[15:0], sample_word);
	end
	initial begin
		void'($urandom(34));
		repeat (10) @(posedge mclk);
		#1 rst = 1'h0;
		cfg_we = 1'h1;
		// last pass writes an unmapped slot, gain must keep 38 dB
		for (i = 0; i < 9; i++) begin
			cfg_addr = i < 8 ? 3'h3 : 3'h5;
			cfg_wdata = {5'($urandom), 3'(i)};
			repeat (2) @(posedge mclk);
			#1 cmp("gain", i < 8 ? 6 * i - (i > 3) * 4 : 38, 16'(input_gain_db));
			cmp("sel", i < 8 ? i : 7, 16'(input_gain_sel));
			if (i < 8) last_wd = cfg_wdata;
		end
		cfg_we = 1'h0;
		cfg_addr = 3'h3;
		@(posedge mclk);
		#1 cmp("rdata", 16'(last_wd), 16'(cfg_rdata));
		k = internal_master_clock;
		@(posedge mclk);
		#1 cmp("imclk", 16'(!k), 16'(internal_master_clock));
		// first five outputs per level are filter settling, not checked
		for (i = 0; i < 2; i++) begin
			#1 pat = i[0];
			mixed_mode = !i;
			ctrl_flag = 1'($urandom);
			repeat (5) notes.push_back(32'h0);
			repeat (2) notes.push_back(i ? 32'hBFFF7FFF : {16'hC000, ctrl_flag, 15'h4000});
			for (k = 0; k < 3000 && notes.size() > 0; k++) @(posedge mclk);
		end
		cmp("drain", 16'h0000, 16'(notes.size()));
		conclude();
	end
endmodule
